// [rtl/mdl_pkg.sv]
// Purpose: shared constants, types and helpers of the display value link
// Assumes: 100 MHz reference clock, 16-bit local register port
// Notes: value type code: bit 1 selects 32-bit, bit 0 selects signed
package mdl_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
	localparam int MS_NS = 1_000_000;
	localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
	localparam int RATE [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
	localparam int GAP_BITS = 40;
	localparam int CHAR_BITS = 11;
	localparam int SEC_MS = 1000;
	localparam int POLL_UNIT_MS = 100;
	localparam int MAX_REGS = 16;
	localparam int BUF_LEN = 48;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [7:0] BCAST = 8'h00;
	localparam logic [7:0] ADDR_ALIAS = 8'hFF;
	localparam logic [7:0] MAX_NODE = 8'hC7;
	localparam logic [6:0] MAX_TMO = 7'h63;
	localparam logic [15:0] MAX_SLOT = 16'h270F;
	localparam logic [7:0] FN_RD = 8'h03;
	localparam logic [7:0] FN_WR1 = 8'h06;
	localparam logic [7:0] FN_WRN = 8'h10;
	localparam logic [7:0] EX_FN = 8'h01;
	localparam logic [7:0] EX_ADR = 8'h02;
	localparam logic [7:0] EX_VAL = 8'h03;
	localparam logic [7:0] EXC_BIT = 8'h80;
	localparam logic [15:0] HR_HI = 16'h0001;
	localparam logic [15:0] HR_LO = 16'h0002;
	localparam logic [15:0] HR_PT = 16'h0003;
	localparam logic [15:0] HR_LOC0 = 16'h0020;
	localparam logic [15:0] HR_CFG_LAST = 16'h0024;
	localparam logic [15:0] HR_LOC_LAST = 16'h0028;
	localparam logic [3:0] RA_CFG = 4'h0;
	localparam logic [3:0] RA_ADDR = 4'h1;
	localparam logic [3:0] RA_VSLOT = 4'h2;
	localparam logic [3:0] RA_PSLOT = 4'h3;
	localparam logic [3:0] RA_POLL = 4'h4;
	localparam logic [3:0] RA_VLO = 4'h5;
	localparam logic [3:0] RA_VHI = 4'h6;
	localparam logic [3:0] RA_PNT = 4'h7;
	localparam logic [3:0] RA_STAT = 4'h8;
	localparam logic [15:0] CFG_RST = 16'h0618;
	localparam logic [7:0] NODE_RST = 8'h01;
	localparam logic [7:0] POLL_RST = 8'h0A;
	localparam logic [1:0] RK_ECHO = 2'h0;
	localparam logic [1:0] RK_READ = 2'h1;
	localparam logic [1:0] RK_EXC = 2'h2;
	localparam logic [1:0] RK_REQ = 2'h3;

	typedef struct packed {
		logic spare;
		logic [2:0] reply_delay;
		logic [2:0] baud;
		logic [2:0] pfix;
		logic point_holding_slot;
		logic reply;
		logic wacc;
		logic [1:0] vtype;
		logic master;
	} mdl_cfg_t;

	typedef enum logic [4:0] {
		ST_RX = 5'h01,
		ST_EXEC = 5'h02,
		ST_WR = 5'h04,
		ST_DLY = 5'h08,
		ST_TX = 5'h10
	} mdl_st_t;

	function automatic logic [16:0] baud_div(input logic [2:0] s);
		return 17'(CLK_HZ / RATE[s]);
	endfunction

	function automatic logic [7:0] reply_delay_chars(input logic [2:0] s);
		case (s)
			3'h1: return 8'h0A;
			3'h2: return 8'h14;
			3'h3: return 8'h32;
			3'h4: return 8'h64;
			3'h5: return 8'hC8;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage

// [rtl/mdl_uart_rx.sv]
// Purpose: serial receiver, 8 data bits, no parity
// Assumes: line input synchronous to clk, div = clock cycles per bit
// Notes: only the first stop bit is checked
`timescale 1ns/1ps
module mdl_uart_rx import mdl_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic rxd,
	input wire logic [16:0] div,
	output logic valid,
	output logic [7:0] data
);
	logic [3:0] n_q, n_d;
	logic [16:0] c_q, c_d;
	logic [7:0] sh_q, sh_d;
	logic v_q, v_d;

	always_comb begin
		n_d = n_q;
		c_d = c_q;
		sh_d = sh_q;
		v_d = 1'b0;
		if (n_q == 4'h0) begin
			if (!rxd) begin
				n_d = 4'h1;
				c_d = div >> 1;
			end
		end else if (c_q <= 17'h00001) begin
			c_d = div;
			if (n_q == 4'h1) begin
				n_d = rxd ? 4'h0 : 4'h2;
			end else if (n_q == 4'hA) begin
				// A second stop bit simply reads as idle line
				v_d = rxd;
				n_d = 4'h0;
			end else begin
				sh_d = {rxd, sh_q[7:1]};
				n_d = n_q + 4'h1;
			end
		end else begin
			c_d = c_q - 17'h00001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			n_q <= 4'h0;
			c_q <= 17'h00000;
			sh_q <= 8'h00;
			v_q <= 1'b0;
		end else begin
			n_q <= n_d;
			c_q <= c_d;
			sh_q <= sh_d;
			v_q <= v_d;
		end
	end

	assign valid = v_q;
	assign data = sh_q;
endmodule

// [rtl/mdl_uart_tx.sv]
// Purpose: serial transmitter, start bit, 8 data bits, two stop bits
// Assumes: start is taken only while busy is low
// Notes: busy rises the cycle after start
`timescale 1ns/1ps
module mdl_uart_tx import mdl_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [16:0] div,
	input wire logic start,
	input wire logic [7:0] data,
	output logic busy,
	output logic txd
);
	logic [10:0] sh_q, sh_d;
	logic [3:0] n_q, n_d;
	logic [16:0] c_q, c_d;

	always_comb begin
		sh_d = sh_q;
		n_d = n_q;
		c_d = c_q;
		if (n_q == 4'h0) begin
			if (start) begin
				sh_d = {2'b11, data, 1'b0};
				n_d = 4'hB;
				c_d = div;
			end
		end else if (c_q <= 17'h00001) begin
			c_d = div;
			sh_d = {1'b1, sh_q[10:1]};
			n_d = n_q - 4'h1;
		end else begin
			c_d = c_q - 17'h00001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sh_q <= 11'h7FF;
			n_q <= 4'h0;
			c_q <= 17'h00000;
		end else begin
			sh_q <= sh_d;
			n_q <= n_d;
			c_q <= c_d;
		end
	end

	assign busy = (n_q != 4'h0);
	assign txd = sh_q[0];
endmodule

// [rtl/mdl_link.sv]
// Purpose: Modbus RTU link of a remote numeric indicator, slave or polling master
// Assumes: half-duplex RS-485 transceiver, TX_EN drives its driver enable
// Notes: local registers on a plain port, mirrored as holding registers 20h-28h
`timescale 1ns/1ps
// How it works
// - A configuration bit picks master (polling) or slave (written) role.
// - Slave answers its node address 0..199; node 0 answers address 255.
// - 16-bit types update on low word; 32-bit need high then low word.
// - Config writes refused when access is off; display registers stay writable.
// - Display writes reply normally only when the reply setting is on.
// - Master polls slave at node address; 0 means address 255.
// - Master reads value slot 0..9999; 32-bit reads two registers, high first.
// - Decimal point is fixed or read from a configured slave register.
// - Master repeats its reads once every poll interval.
// - Bit rate selectable among eight rates from 1200 to 115200.
// - Gap between value updates over timeout flags and blinks; timeout zero disables it.
// - In master role the timeout is lengthened by the poll interval.
// - Optional extra reply delay of 10 to 200 characters, default none.
// - 8N, two stop bits sent, one or two accepted.
// - Functions 03h read, 06h single write, 10h group write.
// - Read and group write cover at most 16 registers.
// - Broadcasts are carried out but never answered.
// - Dashes until first value, blink after timeout, cleared by next value update.
module mdl_link import mdl_pkg::*; #(
	parameter int MS_CYCLES = MS_CYC
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic RXD,
	output logic TXD,
	output logic TX_EN,
	input wire logic [3:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	output logic [31:0] DISP_VALUE,
	output logic [15:0] DISP_POINT,
	output logic DISP_SHOW,
	output logic DISP_BLINK
);
	mdl_st_t st_q, st_d;
	mdl_cfg_t cfg_q, cfg_d;
	logic [7:0] node_q, node_d, poll_q, poll_d, exc_q, exc_d, my_addr;
	logic [6:0] tmo_q, tmo_d;
	logic [13:0] vslot_q, vslot_d, pslot_q, pslot_d;
	logic [31:0] val_q, val_d, lv_data;
	logic [15:0] pnt_q, pnt_d, hi_q, hi_d, rdata_q, rdata_d, lp_data;
	logic [15:0] crc_q, crc_d, tcrc_q, tcrc_d, sa_q, sa_d, mwa, mwd, n16, req_a;
	logic shown_q, shown_d, late_q, late_d, ovf_q, ovf_d, mph_q, mph_d;
	logic pend_q, pend_d, bc_q, bc_d, rpl_q, rpl_d;
	logic mw, lv, lp, upd, frame_ok, disp1, dispn;
	logic [7:0] buf_q [BUF_LEN];
	logic [7:0] buf_d [BUF_LEN];
	logic [5:0] cnt_q, cnt_d, txi_q, txi_d, len_q, len_d, wix;
	logic [4:0] nreg_q, nreg_d, wi_q, wi_d;
	logic [1:0] rk_q, rk_d;
	logic [22:0] sil_q, sil_d, gap_lim;
	logic [29:0] dly_q, dly_d, reply_delay_dly;
	logic [16:0] ms_q, ms_d, gap_q, gap_d, pcnt_q, pcnt_d, lim, plim;
	logic [16:0] cdiv;
	logic ms_tick, poll_tick, rx_v, tx_go, tx_busy;
	logic [7:0] rx_b, tx_b;

	////////////////////////////////////////////////////////////////////////////
	assign cdiv = baud_div(cfg_q.baud);
	assign gap_lim = 23'(cdiv) * 23'(GAP_BITS);
	assign reply_delay_dly = 30'(cdiv) * 30'(CHAR_BITS) * 30'(reply_delay_chars(cfg_q.reply_delay));
	assign my_addr = (node_q == 8'h00) ? ADDR_ALIAS : node_q;

	mdl_uart_rx i_mdl_uart_rx (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.rxd(RXD),
		.div(cdiv),
		.valid(rx_v),
		.data(rx_b)
	);

	mdl_uart_tx i_mdl_uart_tx (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.div(cdiv),
		.start(tx_go),
		.data(tx_b),
		.busy(tx_busy),
		.txd(TXD)
	);

	function automatic logic [15:0] loc_rd(input logic [3:0] a);
		if (a == RA_CFG) return cfg_q;
		else if (a == RA_ADDR) return {1'b0, tmo_q, node_q};
		else if (a == RA_VSLOT) return {2'b00, vslot_q};
		else if (a == RA_PSLOT) return {2'b00, pslot_q};
		else if (a == RA_POLL) return {8'h00, poll_q};
		else if (a == RA_VLO) return val_q[15:0];
		else if (a == RA_VHI) return val_q[31:16];
		else if (a == RA_PNT) return pnt_q;
		else if (a == RA_STAT) return {13'h0000, pend_q, late_q, shown_q};
		else return 16'h0000;
	endfunction

	function automatic logic [15:0] hr_rd(input logic [15:0] a);
		if (a == HR_HI) return val_q[31:16];
		else if (a == HR_LO) return val_q[15:0];
		else if (a == HR_PT) return pnt_q;
		else if (a >= HR_LOC0 && a <= HR_LOC_LAST) return loc_rd(4'(a - HR_LOC0));
		else return 16'h0000;
	endfunction

	function automatic logic [31:0] ext16(input logic [15:0] w);
		return cfg_q.vtype[0] ? {{16{w[15]}}, w} : {16'h0000, w};
	endfunction

	function automatic logic [7:0] gen_byte(input logic [5:0] i);
		logic [15:0] w;
		w = hr_rd(sa_q + {11'h000, 5'((i - 6'h03) >> 1)});
		case (rk_q)
			RK_ECHO: return buf_q[i];
			RK_READ: begin
				if (i < 6'h02) return buf_q[i];
				else if (i == 6'h02) return {2'b00, nreg_q, 1'b0};
				else return i[0] ? w[15:8] : w[7:0];
			end
			RK_EXC: begin
				if (i == 6'h00) return buf_q[0];
				else if (i == 6'h01) return buf_q[1] | EXC_BIT;
				else return exc_q;
			end
			default: begin
				if (i == 6'h00) return my_addr;
				else if (i == 6'h01) return FN_RD;
				else if (i == 6'h02) return sa_q[15:8];
				else if (i == 6'h03) return sa_q[7:0];
				else if (i == 6'h04) return 8'h00;
				else return {3'h0, nreg_q};
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Frame engine
	assign n16 = {buf_q[4], buf_q[5]};
	assign frame_ok = !ovf_q && cnt_q >= 6'h04 && crc_q == 16'h0000;
	// Decoded from the buffer, not from sa_d, so no loop through the frame engine
	assign req_a = {buf_q[2], buf_q[3]};
	assign disp1 = req_a != 16'h0000 && req_a <= HR_PT;
	assign dispn = req_a != 16'h0000 && ({1'b0, req_a} + {1'b0, n16}) <= 17'h00004;
	assign wix = 6'h07 + {wi_q, 1'b0};

	always_comb begin
		st_d = st_q;
		buf_d = buf_q;
		cnt_d = cnt_q;
		crc_d = crc_q;
		ovf_d = ovf_q;
		sil_d = sil_q;
		dly_d = dly_q;
		txi_d = txi_q;
		len_d = len_q;
		tcrc_d = tcrc_q;
		sa_d = sa_q;
		nreg_d = nreg_q;
		wi_d = wi_q;
		exc_d = exc_q;
		rk_d = rk_q;
		mph_d = mph_q;
		bc_d = bc_q;
		rpl_d = rpl_q;
		pend_d = cfg_q.master & (pend_q | poll_tick);
		mw = 1'b0;
		mwa = sa_q;
		mwd = 16'h0000;
		lv = 1'b0;
		lv_data = 32'h00000000;
		lp = 1'b0;
		lp_data = {13'h0000, cfg_q.pfix};
		tx_go = 1'b0;
		if (txi_q < len_q) tx_b = gen_byte(txi_q);
		else if (txi_q == len_q) tx_b = tcrc_q[7:0];
		else tx_b = tcrc_q[15:8];
		case (st_q)
			ST_RX: begin
				if (cfg_q.master && pend_q) begin
					// A new poll abandons any reply still outstanding
					pend_d = poll_tick;
					sa_d = {2'b00, vslot_q};
					nreg_d = cfg_q.vtype[1] ? 5'h02 : 5'h01;
					mph_d = 1'b0;
					rk_d = RK_REQ;
					len_d = 6'h06;
					txi_d = 6'h00;
					tcrc_d = CRC_INIT;
					cnt_d = 6'h00;
					crc_d = CRC_INIT;
					ovf_d = 1'b0;
					st_d = ST_TX;
				end else if (rx_v) begin
					sil_d = 23'h000000;
					if (cnt_q < 6'(BUF_LEN)) begin
						buf_d[cnt_q] = rx_b;
						cnt_d = cnt_q + 6'h01;
						crc_d = crc_step(crc_q, rx_b);
					end else begin
						ovf_d = 1'b1;
					end
				end else if (cnt_q != 6'h00) begin
					if (sil_q >= gap_lim) st_d = ST_EXEC;
					else sil_d = sil_q + 23'h000001;
				end
			end
			ST_EXEC: begin
				cnt_d = 6'h00;
				crc_d = CRC_INIT;
				ovf_d = 1'b0;
				sil_d = 23'h000000;
				txi_d = 6'h00;
				tcrc_d = CRC_INIT;
				dly_d = reply_delay_dly;
				st_d = ST_RX;
				if (!frame_ok) begin
					st_d = ST_RX;
				end else if (cfg_q.master) begin
					if (buf_q[0] == my_addr && buf_q[1] == FN_RD
						&& buf_q[2] == {2'b00, nreg_q, 1'b0}) begin
						if (mph_q) begin
							lp = 1'b1;
							lp_data = {buf_q[3], buf_q[4]};
						end else begin
							lv = 1'b1;
							lv_data = cfg_q.vtype[1] ? {buf_q[3], buf_q[4], buf_q[5], buf_q[6]}
								: ext16({buf_q[3], buf_q[4]});
							lp = !cfg_q.point_holding_slot;
							if (cfg_q.point_holding_slot) begin
								sa_d = {2'b00, pslot_q};
								nreg_d = 5'h01;
								mph_d = 1'b1;
								rk_d = RK_REQ;
								len_d = 6'h06;
								st_d = ST_TX;
							end
						end
					end
				end else if (buf_q[0] == my_addr || buf_q[0] == BCAST) begin
					bc_d = (buf_q[0] == BCAST);
					sa_d = {buf_q[2], buf_q[3]};
					rpl_d = 1'b1;
					rk_d = RK_EXC;
					len_d = 6'h03;
					if (buf_q[1] == FN_RD) begin
						if (n16 == 16'h0000 || n16 > 16'(MAX_REGS)) begin
							exc_d = EX_VAL;
						end else begin
							rk_d = RK_READ;
							nreg_d = n16[4:0];
							len_d = 6'h03 + {n16[4:0], 1'b0};
						end
					end else if (buf_q[1] == FN_WR1) begin
						if (!cfg_q.wacc && !disp1) begin
							exc_d = EX_ADR;
						end else begin
							mw = 1'b1;
							mwa = sa_d;
							mwd = n16;
							rk_d = RK_ECHO;
							len_d = 6'h06;
							rpl_d = !disp1 || cfg_q.reply;
						end
					end else if (buf_q[1] == FN_WRN) begin
						if (n16 == 16'h0000 || n16 > 16'(MAX_REGS) || buf_q[6] != {n16[6:0], 1'b0}
							|| cnt_q != 6'h09 + {n16[4:0], 1'b0}) begin
							exc_d = EX_VAL;
						end else if (!cfg_q.wacc && !dispn) begin
							exc_d = EX_ADR;
						end else begin
							nreg_d = n16[4:0];
							wi_d = 5'h00;
							rk_d = RK_ECHO;
							len_d = 6'h06;
							rpl_d = !dispn || cfg_q.reply;
							st_d = ST_WR;
						end
					end else begin
						exc_d = EX_FN;
					end
					if (st_d == ST_RX && rpl_d && !bc_d) st_d = ST_DLY;
				end
			end
			ST_WR: begin
				mw = 1'b1;
				mwa = sa_q + {11'h000, wi_q};
				mwd = {buf_q[wix], buf_q[wix + 6'h01]};
				wi_d = wi_q + 5'h01;
				if (wi_q == nreg_q - 5'h01) st_d = (rpl_q && !bc_q) ? ST_DLY : ST_RX;
			end
			ST_DLY: begin
				if (dly_q == 30'h00000000) st_d = ST_TX;
				else dly_d = dly_q - 30'h00000001;
			end
			ST_TX: begin
				if (!tx_busy) begin
					if (txi_q == len_q + 6'h02) begin
						st_d = ST_RX;
					end else begin
						tx_go = 1'b1;
						txi_d = txi_q + 6'h01;
						if (txi_q < len_q) tcrc_d = crc_step(tcrc_q, tx_b);
					end
				end
			end
			default: st_d = ST_RX;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		buf_q <= buf_d;
		if (SYS_RST) begin
			st_q <= ST_RX;
			cnt_q <= 6'h00;
			crc_q <= CRC_INIT;
			ovf_q <= 1'b0;
			sil_q <= 23'h000000;
			dly_q <= 30'h00000000;
			txi_q <= 6'h00;
			len_q <= 6'h00;
			tcrc_q <= CRC_INIT;
			sa_q <= 16'h0000;
			nreg_q <= 5'h00;
			wi_q <= 5'h00;
			exc_q <= 8'h00;
			rk_q <= RK_ECHO;
			mph_q <= 1'b0;
			bc_q <= 1'b0;
			rpl_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			crc_q <= crc_d;
			ovf_q <= ovf_d;
			sil_q <= sil_d;
			dly_q <= dly_d;
			txi_q <= txi_d;
			len_q <= len_d;
			tcrc_q <= tcrc_d;
			sa_q <= sa_d;
			nreg_q <= nreg_d;
			wi_q <= wi_d;
			exc_q <= exc_d;
			rk_q <= rk_d;
			mph_q <= mph_d;
			bc_q <= bc_d;
			rpl_q <= rpl_d;
			pend_q <= pend_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Settings and display registers; port 0 is the link, port 1 the local bus
	assign upd = (mw && mwa == HR_LO) || lv;

	always_comb begin
		logic we;
		logic [3:0] wx;
		logic [15:0] wd;
		we = 1'b0;
		wx = 4'h0;
		wd = 16'h0000;
		cfg_d = cfg_q;
		node_d = node_q;
		tmo_d = tmo_q;
		vslot_d = vslot_q;
		pslot_d = pslot_q;
		poll_d = poll_q;
		hi_d = hi_q;
		val_d = val_q;
		pnt_d = pnt_q;
		shown_d = shown_q;
		rdata_d = REG_RD ? loc_rd(REG_ADDR) : 16'h0000;
		for (int p = 0; p < 2; p++) begin
			we = (p == 1) ? REG_WR : (mw && mwa >= HR_LOC0 && mwa <= HR_CFG_LAST);
			wx = (p == 1) ? REG_ADDR : 4'(mwa - HR_LOC0);
			wd = (p == 1) ? REG_WDATA : mwd;
			if (we) begin
				if (wx == RA_CFG) begin
					cfg_d = wd;
				end else if (wx == RA_ADDR) begin
					if (wd[7:0] <= MAX_NODE) node_d = wd[7:0];
					if (wd[14:8] <= MAX_TMO) tmo_d = wd[14:8];
				end else if (wx == RA_VSLOT) begin
					if (wd <= MAX_SLOT) vslot_d = wd[13:0];
				end else if (wx == RA_PSLOT) begin
					if (wd <= MAX_SLOT) pslot_d = wd[13:0];
				end else if (wx == RA_POLL) begin
					poll_d = wd[7:0];
				end
			end
		end
		if (mw && mwa == HR_HI) hi_d = mwd;
		if (upd) begin
			val_d = lv ? lv_data : (cfg_q.vtype[1] ? {hi_q, mwd} : ext16(mwd));
			shown_d = 1'b1;
		end
		if (mw && mwa == HR_PT) pnt_d = mwd;
		if (lp) pnt_d = lp_data;
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			cfg_q <= CFG_RST;
			node_q <= NODE_RST;
			tmo_q <= 7'h00;
			vslot_q <= 14'h0000;
			pslot_q <= 14'h0000;
			poll_q <= POLL_RST;
			hi_q <= 16'h0000;
			val_q <= 32'h00000000;
			pnt_q <= 16'h0000;
			shown_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			cfg_q <= cfg_d;
			node_q <= node_d;
			tmo_q <= tmo_d;
			vslot_q <= vslot_d;
			pslot_q <= pslot_d;
			poll_q <= poll_d;
			hi_q <= hi_d;
			val_q <= val_d;
			pnt_q <= pnt_d;
			shown_q <= shown_d;
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Millisecond timers: poll period and value update timeout
	assign ms_tick = (ms_q == 17'(MS_CYCLES - 1));
	assign plim = 17'(poll_q) * 17'(POLL_UNIT_MS);
	assign poll_tick = ms_tick && pcnt_q >= plim;
	assign lim = 17'(tmo_q) * 17'(SEC_MS) + (cfg_q.master ? plim : 17'h00000);

	always_comb begin
		ms_d = ms_tick ? 17'h00000 : ms_q + 17'h00001;
		pcnt_d = pcnt_q;
		if (ms_tick) pcnt_d = poll_tick ? 17'h00000 : pcnt_q + 17'h00001;
		gap_d = gap_q;
		if (upd) gap_d = 17'h00000;
		else if (ms_tick && gap_q != 17'h1FFFF) gap_d = gap_q + 17'h00001;
		late_d = late_q;
		// Crossing the limit wins over a same-cycle update; a stale overrun does not
		if (tmo_q != 7'h00 && ((ms_tick && gap_q == lim) || (gap_q > lim && !upd)))
			late_d = 1'b1;
		else if (upd) late_d = 1'b0;
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ms_q <= 17'h00000;
			pcnt_q <= 17'h00000;
			gap_q <= 17'h00000;
			late_q <= 1'b0;
		end else begin
			ms_q <= ms_d;
			pcnt_q <= pcnt_d;
			gap_q <= gap_d;
			late_q <= late_d;
		end
	end

	assign TX_EN = (st_q == ST_TX);
	assign REG_RDATA = rdata_q;
	assign DISP_VALUE = val_q;
	assign DISP_POINT = pnt_q;
	assign DISP_SHOW = shown_q;
	assign DISP_BLINK = late_q;
endmodule

// [test/mdl_link_chk.sv]
// Purpose: port assertions of the display value link
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every mdl_link instance
`timescale 1ns/1ps
module mdl_link_chk (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic RXD,
	input wire logic TXD,
	input wire logic TX_EN,
	input wire logic REG_RD,
	input wire logic [15:0] REG_RDATA,
	input wire logic [31:0] DISP_VALUE,
	input wire logic DISP_SHOW,
	input wire logic DISP_BLINK
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SYS_RST);
	property p_rd_idle;
		!$past(REG_RD) |-> REG_RDATA == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data seen outside a read cycle");
	property p_txd_idle;
		!TX_EN |-> TXD;
	endproperty
	a_txd_idle: assert property (p_txd_idle)
		else $error("line not idle high while driver is off");
	property p_tx_start;
		$rose(TX_EN) |-> ##1 !TXD;
	endproperty
	a_tx_start: assert property (p_tx_start)
		else $error("no start bit after driver enable");
	property p_tx_end;
		$fell(TX_EN) |-> TXD && $past(TXD);
	endproperty
	a_tx_end: assert property (p_tx_end)
		else $error("driver released before stop bits");
	property p_show_hold;
		DISP_SHOW |=> DISP_SHOW;
	endproperty
	a_show_hold: assert property (p_show_hold)
		else $error("shown value fell back to dashes");
	// A value only loads once the line has gone quiet for the frame end
	property p_value_quiet;
		!$stable(DISP_VALUE) |-> RXD && $past(RXD, 8);
	endproperty
	a_value_quiet: assert property (p_value_quiet)
		else $error("value changed while a frame was arriving");
	property p_first_clear;
		$rose(DISP_SHOW) |-> !DISP_BLINK;
	endproperty
	a_first_clear: assert property (p_first_clear)
		else $error("first value left blinking on");
	property p_reset_state;
		$fell(SYS_RST) |-> !DISP_SHOW && !TX_EN && REG_RDATA == 16'h0000;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("outputs not in reset state");
endmodule
bind mdl_link mdl_link_chk i_mdl_link_chk (.REF_CLK, .SYS_RST, .RXD, .TXD, .TX_EN, .REG_RD,
	.REG_RDATA, .DISP_VALUE, .DISP_SHOW, .DISP_BLINK);

// [test/mdl_mb_master.sv]
// Purpose: remote bus master model on the serial line
// Assumes: DIV clock cycles per bit
// Notes: sends one stop bit, the device must still accept it
`timescale 1ns/1ps
module mdl_mb_master #(
	parameter int DIV = 868
) (
	input wire logic clk,
	output logic rxd,
	input wire logic txd
);
	logic [7:0] sent[$];
	logic [7:0] got[$];
	logic [7:0] v;
	int stop_bad = 0;
	initial rxd = 1'b1;
	////////////////////////////////////////////////////////////////////////
	task automatic send_bit(input logic b);
		rxd <= b;
		repeat (DIV) @(posedge clk);
	endtask
	task automatic send_frame(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		sent = q;
		foreach (q[i]) begin
			send_bit(1'b0);
			for (int b = 0; b < 8; b++) send_bit(q[i][b]);
			send_bit(1'b1);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// Sample mid-bit; both stop bits must be high
	always begin
		@(negedge txd);
		repeat (DIV / 2) @(posedge clk);
		for (int b = 0; b < 8; b++) begin
			repeat (DIV) @(posedge clk);
			v[b] = txd;
		end
		got.push_back(v);
		repeat (2) begin
			repeat (DIV) @(posedge clk);
			if (txd !== 1'b1) stop_bad++;
		end
	end
endmodule

// [test/mdl_link_test.sv]
// Purpose: self-checking bench of the display value link
// Assumes: 100 MHz clock, ms tick shortened to 20 cycles
// Notes: one serial frame at 115200 keeps the run short
`timescale 1ns/1ps
module mdl_link_test;
	import mdl_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rxd, txd, tx_en, reg_wr = 1'b0, reg_rd = 1'b0, disp_show, disp_blink;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, disp_point;
	logic [31:0] disp_value;
	int bad_count = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	mdl_link #(.MS_CYCLES(20)) i_mdl_link (.REF_CLK(clk), .SYS_RST(rst), .RXD(rxd),
		.TXD(txd), .TX_EN(tx_en), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .DISP_VALUE(disp_value),
		.DISP_POINT(disp_point), .DISP_SHOW(disp_show), .DISP_BLINK(disp_blink));
	mdl_mb_master #(.DIV(CLK_HZ / RATE[7])) i_mdl_mb_master (.clk(clk), .rxd(rxd),
		.txd(txd));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		// Data stand only in the cycle after the strobe; look mid-cycle
		@(negedge clk);
		chk("reg read", {16'h0000, e}, {16'h0000, reg_rdata});
		@(posedge clk);
	endtask
	// Bounded wait on the driver enable, so a silent device cannot hang
	task automatic wait_en(input logic lvl, input int n);
		int i;
		i = 0;
		while (tx_en !== lvl && i < n) begin
			@(posedge clk);
			i++;
		end
		chk("tx_en", {31'h0, lvl}, {31'h0, tx_en});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (300000) @(posedge clk);
		bad_count++;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdchk(RA_CFG, CFG_RST);
		rdchk(RA_ADDR, 16'h0001);
		rdchk(RA_POLL, 16'h000A);
		rdchk(4'h9, 16'h0000);
		wr(RA_VLO, 16'h1111);
		rdchk(RA_VLO, 16'h0000);
		wr(RA_ADDR, 16'h00C8);
		rdchk(RA_ADDR, 16'h0001);
		wr(RA_ADDR, 16'h63C7);
		rdchk(RA_ADDR, 16'h63C7);
		wr(RA_ADDR, 16'h0101);
		wr(RA_CFG, 16'h0E18);
		rdchk(RA_CFG, 16'h0E18);
		chk("show", 32'h0, {31'h0, disp_show});
		i_mdl_mb_master.send_frame({8'h01, FN_WR1, 8'h00, 8'h02, 8'h12, 8'h34});
		wait_en(1'b1, 40000);
		chk("value", 32'h00001234, disp_value);
		chk("show", 32'h1, {31'h0, disp_show});
		chk("blink", 32'h0, {31'h0, disp_blink});
		chk("point", 32'h0, {16'h0, disp_point});
		wait_en(1'b0, 80000);
		repeat (10) @(posedge clk);
		chk("reply bytes", 32'd8, i_mdl_mb_master.got.size());
		for (int i = 0; i < 8 && i < i_mdl_mb_master.got.size(); i++)
			chk("echo", {24'h0, i_mdl_mb_master.sent[i]}, {24'h0, i_mdl_mb_master.got[i]});
		chk("stop bits", 32'h0, i_mdl_mb_master.stop_bad);
		// Reply lasts longer than the shortened 1 s limit
		chk("blink", 32'h1, {31'h0, disp_blink});
		tally_and_finish;
	end
endmodule
